// ### acf_pkg.sv
package acf_pkg;
  localparam int          NPORT       = 15;
  localparam int          AW          = 48;
  localparam int          PW          = 16;
  localparam int          TAGW        = 24;
  localparam int          IDX_TAG_BIT = 23;
  localparam logic [3:0]  UPLINK      = 4'h0;
  localparam logic [14:0] UPLINK_BIT  = 15'h0001;
  localparam logic [14:0] MAP_RST     = 15'h0000;
endpackage

// ### acf_iob_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acf_iob_if;
  import acf_pkg::*;
  logic          start;
  logic [14:0]   map;
  logic [PW-1:0] head;
  logic [PW-1:0] tail;
  logic [PW-1:0] free_top;
  logic          tx_done;
  logic [3:0]    tx_port;
  logic          cont_wr;
  logic [3:0]    cont_port;
  logic [PW-1:0] cont_ptr;
  logic          busy;
  modport ctl (output start, map, head, tail, free_top, tx_done, tx_port,
               cont_wr, cont_port, cont_ptr, input busy);
  modport idx (input start, map, head, tail, free_top, tx_done, tx_port,
               cont_wr, cont_port, cont_ptr, output busy);
endinterface
`default_nettype wire

// ### acf_iob_index.sv
`timescale 1ns/100ps
`default_nettype none
module acf_iob_index
  import acf_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            srst,
  acf_iob_if.idx               bus,
  output logic                 link_valid,
  output logic [14:0]          link_map,
  output logic [PW-1:0]        link_head,
  output logic                 idx_append,
  output logic [TAGW-1:0]      idx_tag,
  output logic                 free_valid,
  output logic [PW-1:0]        free_fwd_addr,
  output logic [PW-1:0]        free_fwd_data,
  output logic [PW-1:0]        free_new_top,
  output logic [PW-1:0]        tx_cont_ptr
);
  typedef enum logic {ST_IDLE, ST_HOLD} acf_idx_st_type;
  typedef struct packed {
    acf_idx_st_type             st;
    logic [14:0]                tag;
    logic [PW-1:0]              ret;
    logic [PW-1:0]              last;
    logic [NPORT-1:0][PW-1:0]   cont;
    logic                       link_valid;
    logic [14:0]                link_map;
    logic [PW-1:0]              link_head;
    logic                       idx_append;
    logic [TAGW-1:0]            idx_tag;
    logic                       free_valid;
    logic [PW-1:0]              free_fwd_addr;
    logic [PW-1:0]              free_fwd_data;
    logic [PW-1:0]              free_new_top;
    logic [PW-1:0]              tx_cont_ptr;
  } acf_idx_state_type;
  acf_idx_state_type q, d;

  // ----------------------------------------------------------------
  // index buffer: one shared frame outstanding at a time
  // ----------------------------------------------------------------
  always_comb begin
    d            = q;
    d.link_valid = 1'b0;
    d.idx_append = 1'b0;
    d.free_valid = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (bus.start) begin
          d.st         = ST_HOLD;
          d.tag        = bus.map;
          d.ret        = bus.head;
          d.last       = bus.tail;
          d.cont       = '0;
          d.link_valid = 1'b1;
          d.link_map   = bus.map;
          d.link_head  = bus.head;
          d.idx_append = 1'b1;
          d.idx_tag    = {9'h000, bus.map};
          d.idx_tag[IDX_TAG_BIT] = 1'b1;
        end
      end
      ST_HOLD: begin
        if (bus.cont_wr && int'(bus.cont_port) < NPORT) begin
          d.cont[bus.cont_port] = bus.cont_ptr;
        end
        if (bus.tx_done && int'(bus.tx_port) < NPORT) begin
          d.tx_cont_ptr      = q.cont[bus.tx_port];
          d.tag[bus.tx_port] = 1'b0;
        end
        // free one cycle after the last tag drops
        if (q.tag == MAP_RST) begin
          d.st            = ST_IDLE;
          d.free_valid    = 1'b1;
          d.free_fwd_addr = q.last;
          d.free_fwd_data = bus.free_top;
          d.free_new_top  = q.ret;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.busy      = (q.st != ST_IDLE);
  assign link_valid    = q.link_valid;
  assign link_map      = q.link_map;
  assign link_head     = q.link_head;
  assign idx_append    = q.idx_append;
  assign idx_tag       = q.idx_tag;
  assign free_valid    = q.free_valid;
  assign free_fwd_addr = q.free_fwd_addr;
  assign free_fwd_data = q.free_fwd_data;
  assign free_new_top  = q.free_new_top;
  assign tx_cont_ptr   = q.tx_cont_ptr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start;
    q.st == ST_IDLE && bus.start;
  endsequence
  sequence s_drained;
    q.st == ST_HOLD && q.tag == MAP_RST;
  endsequence

  AST_IDX_TAG_MARK: assert property (@(posedge clk_sys) disable iff (srst)
    s_start |=> idx_append && idx_tag[IDX_TAG_BIT] && link_valid)
    else $error("index buffer not marked");
  AST_FREE_RETURN: assert property (@(posedge clk_sys) disable iff (srst)
    s_drained |=> free_valid && free_new_top == $past(q.ret)
      && free_fwd_addr == $past(q.last))
    else $error("freeing used wrong pointers");
  AST_FREE_ONLY_EMPTY: assert property (@(posedge clk_sys) disable iff (srst)
    free_valid |-> $past(q.tag) == MAP_RST)
    else $error("buffers freed with ports pending");
endmodule
`default_nettype wire

// ### acf_forward.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - each non-uplink port owns one 48-bit station address register
// - destination compared with all registers; hit yields the port map
// - unmatched with flood set and ordered mode on: send to unassigned ports
// - unmatched without flood: drop if discard set or received on uplink, else send to uplink
// - secured port learns once; unsecured reloads from every source address
// - secured source mismatch suspends or disables the port and flags error
// - same address in two port registers is flagged as an error
// - address registers fully readable and writable through config port
// - uplink seeing a secured address disables itself if enabled to
// - uplink is never suspended for source mismatch
// - ordered mode keeps broadcast transmit order equal to receive order
// - ordered multicast frames are stored and forwarded on receive queue
// - index buffer appended at end of frame, tag bit 23 set
// - targets are active VLAN ports, or active external-match ports
// - each target transmit queue points at the shared receive queue head
// - index buffer keeps one continuation pointer per port
// - tag keeps pending ports; buffers freed after the last clears
// - freeing links free top into last buffer; return address becomes top
// - internal matching never sends a frame back to its receive port
// - without external matching ports 1-14 switch one address each
// - linking stores receive head into transmit queue last forward pointer
module acf_forward
  import acf_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            srst,
  input  wire logic            unmatched_flood,
  input  wire logic            unmatched_discard,
  input  wire logic            ordered_multicast_mode,
  input  wire logic            secure_violation_disable,
  input  wire logic            external_match_en,
  input  wire logic            mismatch_disable,
  input  wire logic [14:0]     port_secured,
  input  wire logic [14:0]     port_active,
  input  wire logic [14:0]     port_reenable,
  input  wire logic            cfg_wr,
  input  wire logic            cfg_rd,
  input  wire logic [3:0]      cfg_port,
  input  wire logic [AW-1:0]   cfg_wdata,
  input  wire logic            rx_valid,
  input  wire logic [3:0]      rx_port,
  input  wire logic [AW-1:0]   rx_da,
  input  wire logic [AW-1:0]   rx_sa,
  input  wire logic            rx_multicast,
  input  wire logic [14:0]     vlan_map,
  input  wire logic [14:0]     external_match_port_map,
  input  wire logic            rx_eof,
  input  wire logic [PW-1:0]   rx_head,
  input  wire logic [PW-1:0]   rx_tail,
  input  wire logic [PW-1:0]   free_top,
  input  wire logic            tx_done,
  input  wire logic [3:0]      tx_port,
  input  wire logic            txq_append,
  input  wire logic [3:0]      txq_port,
  input  wire logic [PW-1:0]   txq_ptr,
  output logic [AW-1:0]        cfg_rdata,
  output logic [14:0]          addr_assigned,
  output logic                 fwd_valid,
  output logic [3:0]           fwd_port,
  output logic [14:0]          fwd_map,
  output logic                 fwd_drop,
  output logic                 fwd_ordered,
  output logic [14:0]          port_suspend,
  output logic [14:0]          port_disable,
  output logic                 err_secure,
  output logic                 err_duplicate,
  output logic                 link_valid,
  output logic [14:0]          link_map,
  output logic [PW-1:0]        link_head,
  output logic                 idx_append,
  output logic [TAGW-1:0]      idx_tag,
  output logic                 free_valid,
  output logic [PW-1:0]        free_fwd_addr,
  output logic [PW-1:0]        free_fwd_data,
  output logic [PW-1:0]        free_new_top,
  output logic [PW-1:0]        tx_cont_ptr
);
  typedef struct packed {
    logic [NPORT-1:0][AW-1:0] addr;
    logic [14:0]              assigned;
    logic [14:0]              suspend;
    logic [14:0]              disable_p;
    logic                     fwd_valid;
    logic [3:0]               fwd_port;
    logic [14:0]              fwd_map;
    logic                     fwd_drop;
    logic                     fwd_ordered;
    logic                     err_secure;
    logic                     err_duplicate;
    logic [AW-1:0]            cfg_rdata;
    logic                     iob_pend;
    logic [14:0]              iob_map;
  } acf_state_type;
  acf_state_type q, d;

  acf_iob_if iob ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [14:0] match_vec(
    input logic [NPORT-1:0][AW-1:0] regs,
    input logic [14:0]              valid,
    input logic [AW-1:0]            a
  );
    logic [14:0] m;
    m = '0;
    for (int i = 0; i < NPORT; i++) begin
      m[i] = valid[i] && (regs[i] == a);
    end
    return m;
  endfunction

  function automatic logic [14:0] onehot(input logic [3:0] p);
    logic [14:0] v;
    v = '0;
    if (int'(p) < NPORT) begin
      v[p] = 1'b1;
    end
    return v;
  endfunction

  logic [14:0] rx_bit;
  logic [14:0] da_hit;
  logic [14:0] sa_hit;
  logic        rx_learn_port;
  logic        cfg_ok;

  assign rx_bit        = onehot(rx_port);
  assign da_hit        = match_vec(q.addr, q.assigned, rx_da);
  assign sa_hit        = match_vec(q.addr, q.assigned, rx_sa);
  // the uplink carries many stations, so it never owns a register
  assign rx_learn_port = rx_port != UPLINK && int'(rx_port) < NPORT;
  assign cfg_ok        = cfg_port != UPLINK && int'(cfg_port) < NPORT;

  // ----------------------------------------------------------------
  // lookup, learning and security
  // ----------------------------------------------------------------
  always_comb begin
    d               = q;
    d.fwd_valid     = 1'b0;
    d.fwd_drop      = 1'b0;
    d.err_secure    = 1'b0;
    d.err_duplicate = 1'b0;
    // re-enable is a plain clear; a violation in the same cycle wins
    d.suspend       = q.suspend & ~port_reenable;
    d.disable_p     = q.disable_p & ~port_reenable;
    // hand-over clears first: a new ordered lookup in that cycle keeps it
    if (iob.start) begin
      d.iob_pend = 1'b0;
    end
    if (rx_valid) begin
      d.fwd_valid   = 1'b1;
      d.fwd_port    = rx_port;
      d.fwd_map     = MAP_RST;
      d.fwd_ordered = 1'b0;
      if (external_match_en) begin
        // echo suppression is left to the external logic here
        d.fwd_map = external_match_port_map & port_active;
      end else if (rx_multicast) begin
        d.fwd_map = vlan_map & port_active & ~rx_bit;
      end else if (|(da_hit & ~rx_bit)) begin
        d.fwd_map = da_hit & ~rx_bit;
      end else if (|da_hit) begin
        d.fwd_drop = 1'b1;
      end else if (unmatched_flood && ordered_multicast_mode) begin
        d.fwd_map     = ~q.assigned & port_active & ~rx_bit;
        d.fwd_ordered = 1'b1;
      end else if (unmatched_discard || rx_port == UPLINK) begin
        d.fwd_drop = 1'b1;
      end else begin
        d.fwd_map = UPLINK_BIT;
      end
      if (rx_multicast && ordered_multicast_mode) begin
        d.fwd_ordered = 1'b1;
      end
      if (d.fwd_map == MAP_RST) begin
        d.fwd_drop = 1'b1;
      end
      if (d.fwd_ordered && !d.fwd_drop) begin
        d.iob_pend = 1'b1;
        d.iob_map  = d.fwd_map;
      end
      if (rx_learn_port) begin
        if (!q.assigned[rx_port]) begin
          d.addr[rx_port]     = rx_sa;
          d.assigned[rx_port] = 1'b1;
        end else if (q.addr[rx_port] != rx_sa) begin
          if (port_secured[rx_port]) begin
            d.err_secure = 1'b1;
            if (mismatch_disable) begin
              d.disable_p[rx_port] = 1'b1;
            end else begin
              d.suspend[rx_port] = 1'b1;
            end
          end else begin
            d.addr[rx_port] = rx_sa;
          end
        end
        if (|(sa_hit & ~rx_bit)) begin
          d.err_duplicate = 1'b1;
        end
      end else if (rx_port == UPLINK && |(sa_hit & port_secured)) begin
        d.err_secure = 1'b1;
        if (secure_violation_disable) begin
          d.disable_p[0] = 1'b1;
        end
      end
    end
    // management write overrides learning in the same cycle
    if (cfg_wr && cfg_ok) begin
      d.addr[cfg_port]     = cfg_wdata;
      d.assigned[cfg_port] = 1'b1;
    end
    if (cfg_rd) begin
      d.cfg_rdata = cfg_ok ? q.addr[cfg_port] : '0;
    end
    // the uplink can never be suspended
    d.suspend[0] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // ordered multicast hand-over
  // ----------------------------------------------------------------
  // one shared frame at a time: an end of frame arriving while the
  // index buffer is held is not linked here and the pend stays set
  assign iob.start     = rx_eof && q.iob_pend && !iob.busy;
  assign iob.map       = q.iob_map;
  assign iob.head      = rx_head;
  assign iob.tail      = rx_tail;
  assign iob.free_top  = free_top;
  assign iob.tx_done   = tx_done;
  assign iob.tx_port   = tx_port;
  assign iob.cont_wr   = txq_append;
  assign iob.cont_port = txq_port;
  assign iob.cont_ptr  = txq_ptr;

  acf_iob_index u_index (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .bus           (iob.idx),
    .link_valid    (link_valid),
    .link_map      (link_map),
    .link_head     (link_head),
    .idx_append    (idx_append),
    .idx_tag       (idx_tag),
    .free_valid    (free_valid),
    .free_fwd_addr (free_fwd_addr),
    .free_fwd_data (free_fwd_data),
    .free_new_top  (free_new_top),
    .tx_cont_ptr   (tx_cont_ptr)
  );

  assign cfg_rdata     = q.cfg_rdata;
  assign addr_assigned = q.assigned;
  assign fwd_valid     = q.fwd_valid;
  assign fwd_port      = q.fwd_port;
  assign fwd_map       = q.fwd_map;
  assign fwd_drop      = q.fwd_drop;
  assign fwd_ordered   = q.fwd_ordered;
  assign port_suspend  = q.suspend;
  assign port_disable  = q.disable_p;
  assign err_secure    = q.err_secure;
  assign err_duplicate = q.err_duplicate;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  logic secure_miss;
  logic plain_miss;
  assign secure_miss = rx_valid && rx_learn_port && q.assigned[rx_port]
    && port_secured[rx_port] && q.addr[rx_port] != rx_sa;
  assign plain_miss  = rx_valid && !external_match_en && !rx_multicast
    && da_hit == MAP_RST && !unmatched_flood && rx_port != UPLINK;

  AST_LOOKUP_ONE_CYCLE: assert property (
    rx_valid |=> fwd_valid && fwd_port == $past(rx_port))
    else $error("lookup answer missing");
  AST_NO_ECHO: assert property (
    fwd_valid && !$past(external_match_en) |-> !fwd_map[fwd_port])
    else $error("frame routed back to its receive port");
  AST_UNMATCHED_UPLINK: assert property (
    plain_miss |=> (fwd_drop == $past(unmatched_discard))
      && (fwd_drop || fwd_map == UPLINK_BIT))
    else $error("unmatched frame handled wrongly");
  AST_FLOOD_ORDERED: assert property (
    rx_valid && !external_match_en && !rx_multicast && da_hit == MAP_RST
      && unmatched_flood && ordered_multicast_mode
    |=> fwd_ordered && (fwd_map & $past(q.assigned)) == MAP_RST)
    else $error("flood reached an assigned port");
  AST_SECURE_HOLD: assert property (
    secure_miss && !cfg_wr |=> err_secure
      && (port_suspend | port_disable) != MAP_RST)
    else $error("secured mismatch not acted on");
  AST_UNSECURED_RELOAD: assert property (
    rx_valid && rx_learn_port && !port_secured[rx_port] && !cfg_wr
    |=> q.addr[$past(rx_port)] == $past(rx_sa))
    else $error("unsecured port did not reload");
  AST_DUPLICATE: assert property (
    rx_valid && rx_learn_port && |(sa_hit & ~rx_bit) |=> err_duplicate)
    else $error("duplicate address not flagged");
  AST_UPLINK_DISABLE: assert property (
    rx_valid && rx_port == UPLINK && |(sa_hit & port_secured)
      && secure_violation_disable |=> port_disable[0])
    else $error("uplink not disabled");
  AST_UPLINK_NO_SUSPEND: assert property (
    !port_suspend[0])
    else $error("uplink suspended");
  AST_CFG_READBACK: assert property (
    cfg_wr && cfg_ok ##1 cfg_rd && $past(cfg_port) == cfg_port
    |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("config readback mismatch");
endmodule
`default_nettype wire

// ### acf_qm_model.sv
`timescale 1ns/100ps
`default_nettype none
// queue manager and external match logic on the far side of the block
module acf_qm_model
  import acf_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          srst,
  input  wire logic          link_valid,
  input  wire logic [14:0]   link_map,
  input  wire logic          free_valid,
  input  wire logic [PW-1:0] free_new_top,
  input  wire logic [3:0]    rx_port,
  input  wire logic [14:0]   ext_pick,
  input  wire logic [3:0]    gap,
  output logic [14:0]        external_match_port_map,
  output logic [PW-1:0]      free_top,
  output logic               tx_done,
  output logic [3:0]         tx_port,
  output logic               txq_append,
  output logic [3:0]         txq_port,
  output logic [PW-1:0]      txq_ptr
);
  logic [14:0] pend;

  // the block does not stop echoes here, so the match logic must
  assign external_match_port_map = ext_pick & ~(15'h0001 << rx_port);

  initial free_top = 16'h3c00;
  always @(negedge clk_sys)
    if (free_valid)
      free_top <= free_new_top;

  // each mapped port appends a continuation, then finishes the shared frame;
  // gap stalls the queue manager to mimic a long transmit queue
  initial begin
    tx_done = 1'h0;
    tx_port = 4'h0;
    txq_append = 1'h0;
    txq_port = 4'h0;
    txq_ptr = 16'h0;
    forever begin
      @(negedge clk_sys);
      if (link_valid === 1'h1 && srst === 1'h0) begin
        pend = link_map;
        for (int p = 0; p < NPORT; p++) begin
          if (pend[p]) begin
            repeat (gap) @(negedge clk_sys);
            txq_append = 1'h1;
            txq_port = p[3:0];
            txq_ptr = 16'h0100 + 16'(p);
            @(negedge clk_sys);
            txq_append = 1'h0;
            tx_done = 1'h1;
            tx_port = p[3:0];
            @(negedge clk_sys);
            tx_done = 1'h0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_acf_forward.sv
`timescale 1ns/100ps
`default_nettype none
module tb_acf_forward;
  import acf_pkg::*;
  localparam logic [AW-1:0] A3 = 48'h02aa00000003;
  localparam logic [AW-1:0] DU = 48'h02bb00000001;
  localparam logic [AW-1:0] MC = 48'h01cc00000001;
  localparam logic [AW-1:0] S7 = 48'h02aa00000007;
  localparam logic [AW-1:0] S8 = 48'h02aa00000008;
  localparam logic [AW-1:0] S9 = 48'h02aa00000009;
  logic          clk_sys = 1'h0, srst = 1'h1, rx_valid = 1'h0, rx_eof = 1'h0;
  logic          rx_multicast = 1'h0, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic          unmatched_flood = 1'h0, unmatched_discard = 1'h0;
  logic          ordered_multicast_mode = 1'h0, external_match_en = 1'h0;
  logic          secure_violation_disable = 1'h0, mismatch_disable = 1'h0;
  logic [3:0]    rx_port = 4'h0, cfg_port = 4'h0, gap = 4'h0;
  logic [14:0]   port_secured = 15'h0, port_active = 15'h7fff;
  logic [14:0]   port_reenable = 15'h0, vlan_map = 15'h0, ext_pick = 15'h0;
  logic [AW-1:0] rx_da = 48'h0, rx_sa = 48'h0, cfg_wdata = 48'h0;
  logic [PW-1:0] rx_head = 16'h0, rx_tail = 16'h0;
  logic          tx_done, txq_append, fwd_valid, fwd_drop, fwd_ordered;
  logic          err_secure, err_duplicate, link_valid, idx_append, free_valid;
  logic [3:0]    tx_port, txq_port, fwd_port;
  logic [PW-1:0] free_top, txq_ptr, link_head, free_fwd_addr;
  logic [PW-1:0] free_fwd_data, free_new_top, tx_cont_ptr;
  logic [14:0]   external_match_port_map, addr_assigned, fwd_map, link_map;
  logic [14:0]   port_suspend, port_disable;
  logic [AW-1:0] cfg_rdata;
  logic [TAGW-1:0] idx_tag;
  int            error_cnt = 0, check_count = 0, n_done = 0;
  logic          d1 = 1'h0, d2 = 1'h0;
  logic [3:0]    p1 = 4'h0, p2 = 4'h0;

  always #2 clk_sys = ~clk_sys;

  acf_forward u_dut (
    .clk_sys, .srst, .unmatched_flood, .unmatched_discard,
    .ordered_multicast_mode, .secure_violation_disable, .external_match_en,
    .mismatch_disable, .port_secured, .port_active, .port_reenable, .cfg_wr,
    .cfg_rd, .cfg_port, .cfg_wdata, .rx_valid, .rx_port, .rx_da, .rx_sa,
    .rx_multicast, .vlan_map, .external_match_port_map, .rx_eof, .rx_head,
    .rx_tail, .free_top, .tx_done, .tx_port, .txq_append, .txq_port,
    .txq_ptr, .cfg_rdata, .addr_assigned, .fwd_valid, .fwd_port, .fwd_map,
    .fwd_drop, .fwd_ordered, .port_suspend, .port_disable, .err_secure,
    .err_duplicate, .link_valid, .link_map, .link_head, .idx_append,
    .idx_tag, .free_valid, .free_fwd_addr, .free_fwd_data, .free_new_top,
    .tx_cont_ptr
  );
  acf_qm_model u_qm (
    .clk_sys, .srst, .link_valid, .link_map, .free_valid, .free_new_top,
    .rx_port, .ext_pick, .gap, .external_match_port_map, .free_top,
    .tx_done, .tx_port, .txq_append, .txq_port, .txq_ptr
  );

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [47:0] e, got);
    check_count++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cfg_access(input logic wr, input logic [3:0] p,
                            input logic [AW-1:0] d);
    @(negedge clk_sys);
    cfg_wr = wr;
    cfg_rd = ~wr;
    cfg_port = p;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'h0;
    cfg_rd = 1'h0;
    @(negedge clk_sys);
    if (!wr)
      chk("cfg_rdata", d, cfg_rdata);
  endtask

  // write, then read the same port back in the very next cycle
  task automatic cfg_wr_rd(input logic [3:0] p, input logic [AW-1:0] d);
    @(negedge clk_sys);
    cfg_wr = 1'h1;
    cfg_port = p;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'h0;
    cfg_rd = 1'h1;
    @(negedge clk_sys);
    cfg_rd = 1'h0;
    chk("cfg_rdata", d, cfg_rdata);
  endtask

  // bounded wait: an answer that never comes shows as a bad fwd_valid
  task automatic lookup(input logic [3:0] p, input logic [AW-1:0] da, sa,
                        input logic mc, input logic [14:0] vm);
    int n;
    @(negedge clk_sys);
    rx_valid = 1'h1;
    rx_port = p;
    rx_da = da;
    rx_sa = sa;
    rx_multicast = mc;
    vlan_map = vm;
    @(negedge clk_sys);
    rx_valid = 1'h0;
    n = 0;
    while (fwd_valid !== 1'h1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    chk("fwd_valid", 1'h1, fwd_valid);
  endtask

  task automatic mc_frame(input logic [14:0] e);
    int n;
    @(negedge clk_sys);
    rx_eof = 1'h1;
    rx_head = rx_head + 16'h0040;
    rx_tail = rx_head + 16'h0007;
    n_done = 0;
    @(negedge clk_sys);
    rx_eof = 1'h0;
    n = 0;
    while (link_valid !== 1'h1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    chk("link_valid", 1'h1, link_valid);
    chk("link_map", e, link_map);
    chk("link_head", rx_head, link_head);
    chk("idx_append", 1'h1, idx_append);
    chk("idx_tag", {1'h1, 8'h0, e}, idx_tag);
    n = 0;
    while (free_valid !== 1'h1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk("free_valid", 1'h1, free_valid);
    chk("tx_done count", 48'($countones(e)), 48'(n_done));
    chk("free_fwd_addr", rx_tail, free_fwd_addr);
    chk("free_fwd_data", free_top, free_fwd_data);
    chk("free_new_top", rx_head, free_new_top);
  endtask

  // continuation pointer is looked at the cycle after each tx_done lands
  always @(posedge clk_sys) begin
    d1 <= tx_done;
    p1 <= tx_port;
    d2 <= d1;
    p2 <= p1;
    if (tx_done === 1'h1)
      n_done++;
  end
  always @(negedge clk_sys)
    if (d2)
      chk("tx_cont_ptr", 48'h0100 + p2, tx_cont_ptr);

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'h0;
    cfg_wr_rd(4'h3, A3);
    cfg_access(1'h1, 4'h0, 48'h02ff00000000);
    cfg_access(1'h0, 4'h3, A3);
    cfg_access(1'h0, 4'h0, 48'h0);
    chk("addr_assigned", 15'h0008, addr_assigned);
    lookup(4'h5, A3, 48'h02aa00000005, 1'h0, 15'h0);
    chk("fwd_map", 15'h0008, fwd_map);
    chk("fwd_port", 4'h5, fwd_port);
    lookup(4'h3, A3, A3, 1'h0, 15'h0);
    chk("fwd_drop", 1'h1, fwd_drop);
    lookup(4'h6, DU, 48'h02aa00000006, 1'h0, 15'h0);
    chk("fwd_map", UPLINK_BIT, fwd_map);
    unmatched_discard = 1'h1;
    lookup(4'h6, DU, 48'h02aa00000006, 1'h0, 15'h0);
    chk("fwd_drop", 1'h1, fwd_drop);
    unmatched_discard = 1'h0;
    unmatched_flood = 1'h1;
    ordered_multicast_mode = 1'h1;
    lookup(4'h6, DU, 48'h02aa00000006, 1'h0, 15'h0);
    chk("fwd_map", 15'h7f97, fwd_map);
    unmatched_flood = 1'h0;
    port_secured = 15'h0080;
    lookup(4'h7, A3, S7, 1'h0, 15'h0);
    lookup(4'h7, A3, S8, 1'h0, 15'h0);
    chk("err_secure", 1'h1, err_secure);
    chk("port_suspend", 15'h0080, port_suspend);
    cfg_access(1'h0, 4'h7, S7);
    mismatch_disable = 1'h1;
    lookup(4'h7, A3, S9, 1'h0, 15'h0);
    chk("port_disable", 15'h0080, port_disable);
    lookup(4'h8, A3, S8, 1'h0, 15'h0);
    lookup(4'h8, A3, S9, 1'h0, 15'h0);
    cfg_access(1'h0, 4'h8, S9);
    lookup(4'h0, DU, S7, 1'h0, 15'h0);
    chk("port_disable", 15'h0080, port_disable);
    secure_violation_disable = 1'h1;
    lookup(4'h0, DU, S7, 1'h0, 15'h0);
    chk("port_disable", 15'h0081, port_disable);
    chk("port_suspend", 15'h0080, port_suspend);
    port_reenable = 15'h7fff;
    @(negedge clk_sys);
    port_reenable = 15'h0;
    @(negedge clk_sys);
    chk("port_disable", 15'h0, port_disable);
    lookup(4'h9, DU, A3, 1'h0, 15'h0);
    chk("err_duplicate", 1'h1, err_duplicate);
    lookup(4'h4, MC, 48'h02aa00000004, 1'h1, 15'h0c06);
    chk("fwd_ordered", 1'h1, fwd_ordered);
    chk("fwd_map", 15'h0c06, fwd_map);
    mc_frame(15'h0c06);
    external_match_en = 1'h1;
    ext_pick = 15'h0033;
    port_active = 15'h7fdf;
    gap = 4'h3;
    lookup(4'h4, MC, 48'h02aa00000004, 1'h1, 15'h0c06);
    mc_frame(15'h0003);
    end_of_test();
  end

  initial begin
    #80000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
